// file: logic/mem_self_test_consts.vh
/*
 * Constants for the memory module self test: presence-detect byte indices,
 * accepted values, sub-test numbering and result layout.
 * Assumes inclusion by its bare name from the self-test design file.
 */
`ifndef MEM_SELF_TEST_CONSTS_VH
`define MEM_SELF_TEST_CONSTS_VH

`define PD_IDX_TYPE      8'h02
`define PD_IDX_ROWS      8'h03
`define PD_IDX_COLS      8'h04
`define PD_IDX_RANKS     8'h05
`define PD_VAL_TYPE_DDR  8'h07
`define PD_VAL_ROWS      8'h0d
`define PD_VAL_COLS      8'h0a
`define PD_VAL_RANKS_1   8'h01
`define PD_VAL_RANKS_2   8'h02

`define SUB_DWALK1       3'h0
`define SUB_DWALK0       3'h1
`define SUB_AWALK1       3'h2
`define SUB_AWALK0       3'h3
`define SUB_COUNT        3'h4
`define SUB_INVERSE      3'h5
`define SUB_NUM          6

`define RES_RESET        12'h000
`define RES_RANK1_BASE   4'h6
`define PRES_SETTLE      2'h2

`endif

// file: logic/mem_self_test.v
/*
 * Built-in self test for a plugged-in DDR memory module: presence check,
 * presence-detect byte checks, then per rank walking-ones/zeros on data and
 * address, counter fill/verify and inverse fill/verify.
 * Assumes a memory controller with a simple request/acknowledge word port
 * and a presence-detect byte reader, both on clk_i.
 */
`include "mem_self_test_consts.vh"

module mem_self_test #(
    parameter DW = 72,
    parameter AW = 26
) (
    input  wire          clk_i,
    input  wire          arst_n_i,
    input  wire          start_i,
    input  wire          present_n_i,
    output reg           pd_req_o,
    output reg  [7:0]    pd_idx_o,
    input  wire          pd_ack_i,
    input  wire [7:0]    pd_data_i,
    output reg           mem_req_o,
    output reg           mem_we_o,
    output reg           mem_rank_o,
    output reg  [AW-1:0] mem_addr_o,
    output reg  [DW-1:0] mem_wdata_o,
    input  wire          mem_ack_i,
    input  wire [DW-1:0] mem_rdata_i,
    output reg           busy_o,
    output reg           done_o,
    output reg           unsupported_o,
    output reg  [1:0]    ranks_o,
    output reg  [11:0]   result_o,
    output reg           err_o,
    output reg  [2:0]    err_test_o,
    output reg           err_rank_o,
    output reg  [AW-1:0] err_addr_o,
    output reg  [DW-1:0] err_exp_o,
    output reg  [DW-1:0] err_act_o
);

    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_PRES = 4'h1;
    localparam [3:0] S_PD   = 4'h2;
    localparam [3:0] S_PDW  = 4'h3;
    localparam [3:0] S_SUB  = 4'h4;
    localparam [3:0] S_ACC  = 4'h5;
    localparam [3:0] S_NEXT = 4'h6;
    localparam [3:0] S_DONE = 4'h7;

    // Index must reach both the top data bit and the address count;
    // eight bits cap the data width at 256, ample for module widths
    localparam IW = (AW + 1 > 8) ? AW + 1 : 8;
    localparam [IW-1:0] LAST_D = DW - 1;
    localparam [IW-1:0] LAST_A = AW;
    localparam [IW-1:0] LAST_C = {{(IW-AW){1'b0}}, {AW{1'b1}}};

    // Presence line is a pin, so it is synchronised first
    reg          pres_s1_r;
    reg          pres_s2_r;
    // Counts the sync flops full after reset, so a start at the first edge is safe
    reg  [1:0]   settle_r;
    reg  [3:0]   state_r;
    reg  [2:0]   sub_r;
    reg          rank_r;
    reg          phase_r;
    reg  [IW-1:0] idx_r;
    reg  [7:0]   pd_type_r;
    reg  [7:0]   pd_rows_r;
    reg  [7:0]   pd_cols_r;
    reg          sub_fail_r;

    wire [DW-1:0] one_d = {{(DW-1){1'b0}}, 1'b1};
    wire [AW-1:0] one_a = {{(AW-1){1'b0}}, 1'b1};
    wire [DW-1:0] cnt_w = {{(DW-AW){1'b0}}, idx_r[AW-1:0]};

    reg  [IW-1:0] last_idx;
    reg  [AW-1:0] addr_c;
    reg  [DW-1:0] data_c;

    // Per sub-test pattern: data walks use index as bit position, address walks index minus one
    always @* begin
        last_idx = {IW{1'b0}};
        addr_c   = {AW{1'b0}};
        data_c   = {DW{1'b0}};
        case (sub_r)
            `SUB_DWALK1: begin
                last_idx = LAST_D;
                data_c   = one_d << idx_r;
            end
            `SUB_DWALK0: begin
                last_idx = LAST_D;
                data_c   = ~(one_d << idx_r);
            end
            `SUB_AWALK1: begin
                // Index 0 is the base address; then each address bit alone
                last_idx = LAST_A;
                addr_c   = (idx_r == 0) ? {AW{1'b0}} : (one_a << (idx_r - 1));
                data_c   = cnt_w;
            end
            `SUB_AWALK0: begin
                last_idx = LAST_A;
                addr_c   = (idx_r == 0) ? {AW{1'b1}} : ~(one_a << (idx_r - 1));
                data_c   = ~cnt_w;
            end
            `SUB_COUNT: begin
                last_idx = LAST_C;
                addr_c   = idx_r[AW-1:0];
                data_c   = cnt_w;
            end
            `SUB_INVERSE: begin
                last_idx = LAST_C;
                addr_c   = idx_r[AW-1:0];
                data_c   = ~cnt_w;
            end
            default: begin
                last_idx = {IW{1'b0}};
            end
        endcase
    end

    // Data walks compare each word at once; others fill then verify
    wire walk_d = (sub_r == `SUB_DWALK1) || (sub_r == `SUB_DWALK0);
    // Rank 1 results sit just above the six rank 0 bits
    wire [3:0] res_bit = rank_r ? ({1'b0, sub_r} + `RES_RANK1_BASE) : {1'b0, sub_r};

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pres_s1_r     <= 1'b1;
            pres_s2_r     <= 1'b1;
            settle_r      <= 2'h0;
            state_r       <= S_IDLE;
            sub_r         <= 3'h0;
            rank_r        <= 1'b0;
            phase_r       <= 1'b0;
            idx_r         <= {IW{1'b0}};
            pd_type_r     <= 8'h00;
            pd_rows_r     <= 8'h00;
            pd_cols_r     <= 8'h00;
            sub_fail_r    <= 1'b0;
            pd_req_o      <= 1'b0;
            pd_idx_o      <= 8'h00;
            mem_req_o     <= 1'b0;
            mem_we_o      <= 1'b0;
            mem_rank_o    <= 1'b0;
            mem_addr_o    <= {AW{1'b0}};
            mem_wdata_o   <= {DW{1'b0}};
            busy_o        <= 1'b0;
            done_o        <= 1'b0;
            unsupported_o <= 1'b0;
            ranks_o       <= 2'h0;
            result_o      <= `RES_RESET;
            err_o         <= 1'b0;
            err_test_o    <= 3'h0;
            err_rank_o    <= 1'b0;
            err_addr_o    <= {AW{1'b0}};
            err_exp_o     <= {DW{1'b0}};
            err_act_o     <= {DW{1'b0}};
        end else begin
            pres_s1_r <= present_n_i;
            pres_s2_r <= pres_s1_r;
            if (settle_r != `PRES_SETTLE) begin
                settle_r <= settle_r + 2'h1;
            end
            case (state_r)
                S_IDLE: begin
                    if (start_i) begin
                        busy_o        <= 1'b1;
                        done_o        <= 1'b0;
                        unsupported_o <= 1'b0;
                        err_o         <= 1'b0;
                        result_o      <= `RES_RESET;
                        ranks_o       <= 2'h0;
                        state_r       <= S_PRES;
                    end
                end
                S_PRES: begin
                    if (settle_r != `PRES_SETTLE) begin
                        // Synchroniser may still hold its reset value; wait
                        state_r <= S_PRES;
                    end else if (pres_s2_r) begin
                        unsupported_o <= 1'b1;
                        state_r       <= S_DONE;
                    end else begin
                        pd_idx_o <= `PD_IDX_TYPE;
                        state_r  <= S_PD;
                    end
                end
                S_PD: begin
                    pd_req_o <= 1'b1;
                    state_r  <= S_PDW;
                end
                S_PDW: begin
                    if (pd_ack_i) begin
                        pd_req_o <= 1'b0;
                        case (pd_idx_o)
                            `PD_IDX_TYPE: pd_type_r <= pd_data_i;
                            `PD_IDX_ROWS: pd_rows_r <= pd_data_i;
                            `PD_IDX_COLS: pd_cols_r <= pd_data_i;
                            default: pd_cols_r <= pd_cols_r;
                        endcase
                        if (pd_idx_o == `PD_IDX_RANKS) begin
                            if (pd_type_r == `PD_VAL_TYPE_DDR &&
                                pd_rows_r == `PD_VAL_ROWS &&
                                pd_cols_r == `PD_VAL_COLS &&
                                (pd_data_i == `PD_VAL_RANKS_1 ||
                                 pd_data_i == `PD_VAL_RANKS_2)) begin
                                ranks_o    <= pd_data_i[1:0];
                                rank_r     <= 1'b0;
                                sub_r      <= `SUB_DWALK1;
                                state_r    <= S_SUB;
                            end else begin
                                unsupported_o <= 1'b1;
                                state_r       <= S_DONE;
                            end
                        end else begin
                            pd_idx_o <= pd_idx_o + 8'h01;
                            state_r  <= S_PD;
                        end
                    end
                end
                S_SUB: begin
                    idx_r      <= {IW{1'b0}};
                    phase_r    <= 1'b0;
                    sub_fail_r <= 1'b0;
                    state_r    <= S_ACC;
                end
                S_ACC: begin
                    if (!mem_req_o) begin
                        mem_req_o   <= 1'b1;
                        mem_we_o    <= ~phase_r;
                        mem_rank_o  <= rank_r;
                        mem_addr_o  <= addr_c;
                        mem_wdata_o <= data_c;
                    end else if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        if (!mem_we_o && mem_rdata_i != data_c) begin
                            sub_fail_r <= 1'b1;
                            if (!err_o) begin
                                // Only the first failure is kept for reporting
                                err_o      <= 1'b1;
                                err_test_o <= sub_r;
                                err_rank_o <= rank_r;
                                err_addr_o <= mem_addr_o;
                                err_exp_o  <= data_c;
                                err_act_o  <= mem_rdata_i;
                            end
                        end
                        if (walk_d && !phase_r) begin
                            phase_r <= 1'b1;
                        end else if (walk_d) begin
                            phase_r <= 1'b0;
                            if (idx_r == last_idx) state_r <= S_NEXT;
                            else idx_r <= idx_r + 1'b1;
                        end else if (idx_r != last_idx) begin
                            idx_r <= idx_r + 1'b1;
                        end else if (!phase_r) begin
                            phase_r <= 1'b1;
                            idx_r   <= {IW{1'b0}};
                        end else begin
                            state_r <= S_NEXT;
                        end
                    end
                end
                S_NEXT: begin
                    result_o[res_bit] <= ~sub_fail_r;
                    if (sub_r != `SUB_INVERSE) begin
                        sub_r   <= sub_r + 3'h1;
                        state_r <= S_SUB;
                    end else if (!rank_r && ranks_o == `PD_VAL_RANKS_2) begin
                        rank_r  <= 1'b1;
                        sub_r   <= `SUB_DWALK1;
                        state_r <= S_SUB;
                    end else begin
                        state_r <= S_DONE;
                    end
                end
                S_DONE: begin
                    busy_o  <= 1'b0;
                    done_o  <= 1'b1;
                    state_r <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

endmodule // mem_self_test

// file: verif/mem_self_test_properties.sv
/* Port assertions for the memory self test.
   Assumes bind into mem_self_test with one clock domain. */
module mem_self_test_properties #(parameter DW = 72, parameter AW = 26) (
    input wire logic          clk_i,
    input wire logic          arst_n_i,
    input wire logic          start_i,
    input wire logic          pd_req_o,
    input wire logic [7:0]    pd_idx_o,
    input wire logic          pd_ack_i,
    input wire logic          mem_req_o,
    input wire logic          mem_we_o,
    input wire logic          mem_rank_o,
    input wire logic [AW-1:0] mem_addr_o,
    input wire logic [DW-1:0] mem_wdata_o,
    input wire logic          mem_ack_i,
    input wire logic          busy_o,
    input wire logic          done_o,
    input wire logic          unsupported_o,
    input wire logic [1:0]    ranks_o,
    input wire logic          err_o,
    input wire logic [AW-1:0] err_addr_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_pd_hold: assert property (pd_req_o && !pd_ack_i |=> pd_req_o && $stable(pd_idx_o)) else $error("pd req dropped");
    a_pd_index: assert property (pd_req_o |-> pd_idx_o >= 8'h02 && pd_idx_o <= 8'h05) else $error("pd index");
    a_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable({mem_we_o, mem_rank_o, mem_addr_o, mem_wdata_o})) else $error("mem req dropped");
    a_idle_quiet: assert property (!busy_o |-> !pd_req_o && !mem_req_o) else $error("request while idle");
    a_unsup_quiet: assert property (unsupported_o |-> !mem_req_o && ranks_o == 2'h0) else $error("memory used unsupported");
    a_rank_in: assert property (mem_req_o |-> {1'b0, mem_rank_o} < ranks_o) else $error("rank out of range");
    a_done_holds: assert property (done_o && !start_i |=> done_o) else $error("done dropped");
    a_err_sticky: assert property (err_o && !start_i |=> err_o && $stable(err_addr_o)) else $error("error lost");
    c_done: cover property (done_o && !unsupported_o);
    c_unsup: cover property (unsupported_o);
    c_err: cover property (err_o);
    c_rank1: cover property (mem_req_o && mem_rank_o);
endmodule // mem_self_test_properties

bind mem_self_test mem_self_test_properties #(.DW(DW), .AW(AW)) i_mem_self_test_properties (.*);

// file: verif/mem_module_model.sv
/* Behavioural memory module with its presence-detect store.
   Assumes the tester's request/acknowledge ports on the same clock. */
module mem_module_model #(parameter DW = 72, parameter AW = 26) (
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    input  wire logic [31:0]   spd_i,
    input  wire logic          fault_i,
    input  wire logic          slow_i,
    input  wire logic          pd_req_i,
    input  wire logic [7:0]    pd_idx_i,
    output logic               pd_ack_o,
    output logic [7:0]         pd_data_o,
    input  wire logic          mem_req_i,
    input  wire logic          mem_we_i,
    input  wire logic          mem_rank_i,
    input  wire logic [AW-1:0] mem_addr_i,
    input  wire logic [DW-1:0] mem_wdata_i,
    output logic               mem_ack_o,
    output logic [DW-1:0]      mem_rdata_o,
    output int                 n_pd_o,
    output int                 n_mem_o,
    output int                 n_r1_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Two ranks of DW-bit words, so 64 and 72 bit parts alike fit
    logic [DW-1:0] mem_r [0:2**(AW+1)-1];
    logic [1:0]    wait_r;
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pd_ack_o <= 1'b0;
            mem_ack_o <= 1'b0;
            pd_data_o <= 8'h00;
            mem_rdata_o <= '0;
            wait_r <= 2'h0;
            n_pd_o <= 0;
            n_mem_o <= 0;
            n_r1_o <= 0;
        end else begin
            pd_ack_o <= 1'b0;
            mem_ack_o <= 1'b0;
            // Lines not carrying an answer toggle, so stale data never matches
            pd_data_o <= ~pd_data_o;
            mem_rdata_o <= ~mem_rdata_o;
            if ((pd_req_i || mem_req_i) && !pd_ack_o && !mem_ack_o) begin
                wait_r <= wait_r + 2'h1;
                if (wait_r == (slow_i ? 2'h3 : 2'h0)) begin
                    wait_r <= 2'h0;
                    if (pd_req_i) begin
                        pd_ack_o <= 1'b1;
                        pd_data_o <= spd_i[8*(5-pd_idx_i) +: 8];
                        n_pd_o <= n_pd_o + 1;
                    end else begin
                        mem_ack_o <= 1'b1;
                        n_mem_o <= n_mem_o + 1;
                        n_r1_o <= n_r1_o + mem_rank_i;
                        if (mem_we_i)
                            mem_r[{mem_rank_i, mem_addr_i}] <= mem_wdata_i ^ {{(DW-2){1'b0}}, fault_i, 1'b0};
                        else
                            mem_rdata_o <= mem_r[{mem_rank_i, mem_addr_i}];
                    end
                end
            end
        end
    end
endmodule // mem_module_model

// file: verif/tb_mem_self_test.sv
/* Self-checking bench for the memory self test.
   Assumes the module model answers both request ports. */
`include "mem_self_test_consts.vh"
module tb_mem_self_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DW = 72;
    localparam int AW = 4;
    // Accesses per rank: every pattern word is written once and read once
    localparam int N_ACC = 4 * DW + 4 * (AW + 1) + 4 * (2 ** AW);
    logic clk_i = 1'b0, arst_n_i = 1'b0, start_i = 1'b0, present_n_i = 1'b0;
    logic fault = 1'b0, slow = 1'b0, pd_req_o, pd_ack_i, mem_req_o, mem_we_o, mem_rank_o;
    logic mem_ack_i, busy_o, done_o, unsupported_o, err_o, err_rank_o;
    logic [31:0] spd = 32'h070d0a02;
    logic [7:0] pd_idx_o, pd_data_i;
    logic [1:0] ranks_o;
    logic [2:0] err_test_o;
    logic [11:0] result_o, exp_res;
    logic [AW-1:0] mem_addr_o, err_addr_o;
    logic [DW-1:0] mem_wdata_o, mem_rdata_i, err_exp_o, err_act_o;
    int n_errors = 0, total_checks = 0, cycles = 0, n_pd, n_mem, n_r1, dp, dm, d1;
    typedef struct {logic [31:0] spd; logic unsup; logic [1:0] ranks;} row_t;
    row_t rows [7] = '{'{32'h070d0a01, 1'b0, 2'h1}, '{32'h070d0a02, 1'b0, 2'h2},
        '{32'h060d0a02, 1'b1, 2'h0}, '{32'h070c0a02, 1'b1, 2'h0},
        '{32'h070d0b02, 1'b1, 2'h0}, '{32'h070d0a03, 1'b1, 2'h0},
        '{32'h070d0a00, 1'b1, 2'h0}};
    mem_self_test #(.DW(DW), .AW(AW)) i_mem_self_test (.*);
    mem_module_model #(.DW(DW), .AW(AW)) i_mem_module_model (.clk_i, .arst_n_i,
        .spd_i(spd), .fault_i(fault), .slow_i(slow), .pd_req_i(pd_req_o),
        .pd_idx_i(pd_idx_o), .pd_ack_o(pd_ack_i), .pd_data_o(pd_data_i),
        .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_rank_i(mem_rank_o),
        .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i), .n_pd_o(n_pd), .n_mem_o(n_mem), .n_r1_o(n_r1));
    always #2.5 clk_i = ~clk_i;
    // Ten runs of at most some 5000 cycles each fit well under the ceiling
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input string what, input logic [DW-1:0] exp, input logic [DW-1:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task run();
        int p0, m0, r0, k;
        p0 = n_pd;
        m0 = n_mem;
        r0 = n_r1;
        k = 0;
        @(negedge clk_i) start_i = 1'b1;
        @(negedge clk_i) start_i = 1'b0;
        while (done_o !== 1'b1 && k < 10000) begin
            @(negedge clk_i);
            k++;
        end
        check("done_o", 1, done_o);
        dp = n_pd - p0;
        dm = n_mem - m0;
        d1 = n_r1 - r0;
    endtask
    initial begin
        repeat (3) @(negedge clk_i);
        check("busy_o", 0, busy_o);
        check("result_o", 0, result_o);
        arst_n_i = 1'b1;
        for (int i = 0; i < 7; i++) begin
            spd = rows[i].spd;
            slow = i[0];
            run();
            check("unsupported_o", rows[i].unsup, unsupported_o);
            check("ranks_o", rows[i].ranks, ranks_o);
            check("pd_reads", 4, dp);
            check("mem_used", !rows[i].unsup, dm != 0);
            check("mem_count", rows[i].ranks * N_ACC, dm);
            check("rank1_used", rows[i].ranks == 2'h2, d1 != 0);
            check("rank1_count", (rows[i].ranks == 2'h2) ? N_ACC : 0, d1);
            exp_res = rows[i].unsup ? 12'h000 : (rows[i].ranks == 2'h2 ? 12'hfff : 12'h03f);
            check("result_o", exp_res, result_o);
            check("err_o", 0, err_o);
            $display("row %0d finished", i);
        end
        present_n_i = 1'b1;
        run();
        check("unsupported_o", 1, unsupported_o);
        check("pd_reads", 0, dp);
        check("mem_used", 0, dm);
        $display("absent module finished");
        present_n_i = 1'b0;
        spd = 32'h070d0a02;
        fault = 1'b1;
        run();
        check("err_o", 1, err_o);
        check("err_test_o", `SUB_DWALK1, err_test_o);
        check("err_rank_o", 0, err_rank_o);
        check("err_flip", 2, err_exp_o ^ err_act_o);
        check("err_addr_o", 0, err_addr_o);
        check("err_exp_o", 1, err_exp_o);
        check("result_o", 12'h000, result_o);
        $display("stuck bit finished");
        fault = 1'b0;
        spd = 32'h070d0a01;
        @(negedge clk_i) start_i = 1'b1;
        @(negedge clk_i) start_i = 1'b0;
        repeat (40) @(negedge clk_i);
        arst_n_i = 1'b0;
        @(negedge clk_i);
        check("busy_o", 0, busy_o);
        check("done_o", 0, done_o);
        check("err_o", 0, err_o);
        // Start at the first edge after release; presence must still be seen
        arst_n_i = 1'b1;
        start_i = 1'b1;
        run();
        check("unsupported_o", 0, unsupported_o);
        check("mem_count", N_ACC, dm);
        check("result_o", 12'h03f, result_o);
        $display("mid-run reset finished");
        tally_and_finish();
    end
endmodule // tb_mem_self_test
